// *** bench/aafm_cpu.sv ***
// controller model: drives the register port and services alarms
// assumes the register port timing of aafm_top on core_clk
`timescale 1ns/1ps
module aafm_cpu (
    // clock
    input  wire logic        core_clk,
    // register port
    output logic      [7:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata
);
    import aafm_pkg::*;
    // ========================================================
    // idle bus
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // ========================================================
    // bus cycles
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    // ========================================================
    // channel commands
    task automatic set_thr(input logic [2:0] ch, input logic [15:0] cfg,
        input logic [15:0] hi, input logic [15:0] lo);
        wr(ADDR_CHSEL, {13'h0000, ch});
        wr(ADDR_CFG, cfg);
        wr(ADDR_HI, hi);
        wr(ADDR_LO, lo);
    endtask : set_thr
    task automatic val(input logic [2:0] ch, output logic [15:0] d);
        wr(ADDR_CHSEL, {13'h0000, ch});
        rd(ADDR_VALUE, d);
    endtask : val
    // refresh the channel value first, then acknowledge the alarm
    task automatic service(input logic [2:0] ch, output logic [15:0] d);
        val(ch, d);
        wr(ADDR_ACK, {13'h0000, ch});
    endtask : service
endmodule : aafm_cpu

// *** bench/test_analog_alarm_fault_monitor.sv ***
// self-checking bench for the alarm comparator and fault monitor
// assumes aafm_top with eight channels and the aafm_cpu model
`timescale 1ns/1ps
module test_analog_alarm_fault_monitor;
    import aafm_pkg::*;
    // ========================================================
    // signals
    logic               core_clk;
    logic               rstn;
    logic [7:0]         reg_addr;
    logic [15:0]        reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [15:0]        reg_rdata;
    logic               smp_valid;
    logic [2:0]         smp_ch;
    logic signed [19:0] smp_scaled;
    logic [15:0]        smp_raw_mag;
    logic               smp_adc_over;
    logic               smp_adc_under;
    logic               smp_current_mode;
    logic               smp_base;
    logic               exp_no_resp;
    logic               adc_comm_fail;
    logic               scale_zero_bad;
    logic               exp_scan_done;
    logic               exp_scan_mismatch;
    logic [7:0]         high_alarm_contact;
    logic [7:0]         low_alarm_contact;
    logic [7:0]         fault_contact;
    logic [7:0]         no_fault_contact;
    logic [7:0]         alarm_irq;
    logic               fault_msg_valid;
    logic [15:0]        fault_msg;
    logic               leds_on;
    logic               halted;
    logic [15:0]        last_msg;
    int                 msg_cnt;
    int                 error_cnt;
    int                 checked;
    int                 cyc;
    // ========================================================
    // instances
    aafm_top #(.NCH(8), .CW(3)) uut (.*);
    aafm_cpu cpu (.*);
    // ========================================================
    // clock, timeout and message monitor
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (fault_msg_valid === 1'b1) begin
            msg_cnt++;
            last_msg = fault_msg;
        end
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    // ========================================================
    // helpers
    task automatic chk(input string nm, input logic [15:0] got,
        input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic summarize();
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    task automatic do_reset();
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
    endtask : do_reset
    // fl is {base, current mode, raw under, raw over}
    task automatic smp(input logic [2:0] ch, input logic signed [19:0] v,
        input logic [3:0] fl, input logic [15:0] raw);
        @(posedge core_clk);
        smp_valid        <= 1'b1;
        smp_ch           <= ch;
        smp_scaled       <= v;
        smp_raw_mag      <= raw;
        {smp_base, smp_current_mode, smp_adc_under, smp_adc_over} <= fl;
        @(posedge core_clk);
        smp_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : smp
    // ========================================================
    // scenarios
    task automatic t_reset();
        logic [15:0] d;
        chk("no fault contacts", 16'(no_fault_contact), 16'h00FF);
        chk("leds", 16'(leds_on), 16'h0001);
        cpu.wr(ADDR_CHSEL, 16'h0003);
        cpu.rd(ADDR_HI, d);
        chk("high threshold", d, 16'h7FFF);
        cpu.rd(ADDR_LO, d);
        chk("low threshold", d, 16'h8001);
        cpu.rd(ADDR_STAT, d);
        chk("status", d, 16'h0008);
        cpu.rd(8'h1F, d);
        chk("unmapped", d, 16'h0000);
    endtask : t_reset
    task automatic t_alarm();
        logic [15:0] d;
        cpu.set_thr(3'd2, 16'h1000, 16'h0064, 16'hFF9C);
        smp(3'd2, 20'sd200, 4'b1000, 16'h2000);
        chk("high contact", 16'(high_alarm_contact[2]), 16'h0001);
        chk("low contact", 16'(low_alarm_contact[2]), 16'h0000);
        chk("irq", 16'(alarm_irq[2]), 16'h0001);
        cpu.service(3'd2, d);
        chk("value", d, 16'h00C8);
        repeat (2) @(posedge core_clk);
        #1;
        chk("high acked", 16'(high_alarm_contact[2]), 16'h0000);
        smp(3'd2, 20'sd300, 4'b1000, 16'h2000);
        chk("no second alarm", 16'(high_alarm_contact[2]), 16'h0000);
        smp(3'd2, 20'sd0, 4'b1000, 16'h2000);
        smp(3'd2, -20'sd200, 4'b1000, 16'h2000);
        chk("low contact", 16'(low_alarm_contact[2]), 16'h0001);
        chk("irq low", 16'(alarm_irq[2]), 16'h0001);
        cpu.service(3'd2, d);
        chk("value low", d, 16'hFF38);
        cpu.set_thr(3'd2, 16'h0000, 16'h0064, 16'hFF9C);
        smp(3'd2, 20'sd0, 4'b1000, 16'h2000);
        smp(3'd2, 20'sd200, 4'b1000, 16'h2000);
        chk("irq masked", 16'(alarm_irq[2]), 16'h0000);
        chk("high again", 16'(high_alarm_contact[2]), 16'h0001);
    endtask : t_alarm
    task automatic t_disable();
        cpu.set_thr(3'd4, 16'h1000, 16'h7FFF, 16'h8001);
        smp(3'd4, 20'sd40000, 4'b1000, 16'h2000);
        chk("high off", 16'(high_alarm_contact[4]), 16'h0000);
        smp(3'd4, -20'sd40000, 4'b1000, 16'h2000);
        chk("low off", 16'(low_alarm_contact[4]), 16'h0000);
        cpu.set_thr(3'd5, 16'h1000, 16'h0064, 16'hFF9C);
        smp(3'd5, 20'sd200, 4'b0000, 16'h2000);
        chk("expander alarm", 16'(high_alarm_contact[5]), 16'h0000);
    endtask : t_disable
    task automatic t_fault();
        logic signed [19:0] tv [4] = '{-20'sd40000, 20'sd100, 20'sd100, 0};
        logic [3:0]  tf [4] = '{4'b1000, 4'b1001, 4'b1010, 4'b1100};
        logic [15:0] tr [4] = '{16'h2000, 16'h2000, 16'h2000, 16'h0F9F};
        logic [15:0] tx [4] = '{16'h8001, 16'h0064, 16'h0064, 16'h0000};
        logic [2:0]  tc [4] = '{3'd1, 3'd0, 3'd1, 3'd2};
        logic [15:0] d;
        int          n;
        cpu.set_thr(3'd6, 16'h0000, 16'h7FFF, 16'h8001);
        n = msg_cnt;
        smp(3'd6, 20'sd40000, 4'b1000, 16'h2000);
        chk("fault contact", 16'(fault_contact[6]), 16'h0001);
        chk("no fault off", 16'(no_fault_contact[6]), 16'h0000);
        chk("msg count", 16'(msg_cnt - n), 16'h0001);
        chk("msg", last_msg, 16'h0600);
        cpu.val(3'd6, d);
        chk("clamped", d, 16'h7FFF);
        smp(3'd6, 20'sd40000, 4'b1000, 16'h2000);
        chk("repeat msg", 16'(msg_cnt - n), 16'h0001);
        smp(3'd6, 20'sd0, 4'b1000, 16'h2000);
        chk("fault clear", 16'(no_fault_contact[6]), 16'h0001);
        smp(3'd6, 20'sd40000, 4'b1000, 16'h2000);
        chk("recur msg", 16'(msg_cnt - n), 16'h0002);
        smp(3'd6, 20'sd0, 4'b1000, 16'h2000);
        for (int i = 0; i < 4; i++) begin
            n = msg_cnt;
            smp(3'd6, tv[i], tf[i], tr[i]);
            chk("code msg", last_msg, {13'h00C0, tc[i]});
            chk("code count", 16'(msg_cnt - n), 16'h0001);
            cpu.val(3'd6, d);
            chk("code value", d, tx[i]);
            smp(3'd6, 20'sd0, 4'b1000, 16'h2000);
        end
        cpu.set_thr(3'd7, 16'h0080, 16'h7FFF, 16'h8001);
        n = msg_cnt;
        smp(3'd7, 20'sd40000, 4'b1000, 16'h2000);
        chk("silent fault", 16'(fault_contact[7]), 16'h0001);
        chk("silent count", 16'(msg_cnt - n), 16'h0000);
    endtask : t_fault
    task automatic t_module();
        exp_no_resp <= 1'b1;
        repeat (20) @(posedge core_clk);
        #1;
        chk("expander fault", 16'(fault_contact), 16'h00FF);
        exp_no_resp <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        chk("expander clear", 16'(no_fault_contact[0]), 16'h0001);
        exp_scan_mismatch <= 1'b1;
        exp_scan_done     <= 1'b1;
        @(posedge core_clk);
        exp_scan_done <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        chk("scan fault", 16'(fault_contact[0]), 16'h0001);
        exp_scan_mismatch <= 1'b0;
    endtask : t_module
    task automatic t_halt(input logic [2:0] code);
        int n;
        do_reset();
        n = msg_cnt;
        if (code == 3'(F_ADC)) begin
            adc_comm_fail <= 1'b1;
        end else begin
            scale_zero_bad <= 1'b1;
        end
        repeat (40) @(posedge core_clk);
        #1;
        chk("halted", 16'(halted), 16'h0001);
        chk("leds off", 16'(leds_on), 16'h0000);
        chk("halt msg", 16'(msg_cnt > n), 16'h0001);
        chk("halt code", 16'(last_msg[2:0]), 16'(code));
        adc_comm_fail  <= 1'b0;
        scale_zero_bad <= 1'b0;
    endtask : t_halt
    // ========================================================
    // main sequence
    initial begin
        rstn              = 1'b0;
        smp_valid         = 1'b0;
        smp_ch            = 3'd0;
        smp_scaled        = 20'sd0;
        smp_raw_mag       = 16'h2000;
        {smp_base, smp_current_mode, smp_adc_under, smp_adc_over} = 4'h8;
        exp_no_resp       = 1'b0;
        adc_comm_fail     = 1'b0;
        scale_zero_bad    = 1'b0;
        exp_scan_done     = 1'b0;
        exp_scan_mismatch = 1'b0;
        do_reset();
        #1;
        t_reset();
        t_alarm();
        t_disable();
        t_fault();
        t_module();
        t_halt(3'(F_SCALE));
        t_halt(3'(F_ADC));
        summarize();
    end
endmodule : test_analog_alarm_fault_monitor

// *** rtl/aafm_mem.sv ***
// small register-output memory for per channel words
// assumes one write port and one read port on core_clk
`timescale 1ns/1ps
module aafm_mem #(
    parameter int unsigned AW = 3,
    parameter int unsigned DW = 16,
    parameter logic [DW-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rstn,
    // write
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // read
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem_q [2**AW];
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= INIT;
            end
        end else if (we) begin
            mem_q[waddr] <= wdata;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= INIT;
        end else begin
            rdata <= mem_q[raddr];
        end
    end
endmodule : aafm_mem

// *** rtl/aafm_pkg.sv ***
// package for the analog alarm and fault monitor
// assumes a single 20 MHz core clock domain
package aafm_pkg;
    // =========================================================
    // clock
    localparam int unsigned CLK_HZ = 20000000;
    // =========================================================
    // data limits
    localparam logic signed [15:0] FULL_POS = 16'sh7FFF;
    localparam logic signed [15:0] FULL_NEG = 16'sh8001;
    localparam logic signed [19:0] WIDE_POS = 20'sh07FFF;
    localparam logic signed [19:0] WIDE_NEG = -20'sh07FFF;
    // open wire threshold in raw current units of 0.5 uA
    localparam logic [15:0] OPEN_WIRE_RAW = 16'h0FA0;
    // =========================================================
    // register map
    localparam logic [7:0] ADDR_CFG    = 8'h00;
    localparam logic [7:0] ADDR_HI     = 8'h01;
    localparam logic [7:0] ADDR_LO     = 8'h02;
    localparam logic [7:0] ADDR_STAT   = 8'h03;
    localparam logic [7:0] ADDR_VALUE  = 8'h04;
    localparam logic [7:0] ADDR_ACK    = 8'h05;
    localparam logic [7:0] ADDR_FAULT  = 8'h06;
    localparam logic [7:0] ADDR_MSG    = 8'h07;
    localparam logic [7:0] ADDR_CHSEL  = 8'h08;
    // configuration word fields, bit 1 is the lsb
    localparam int unsigned CFG_FLT_DIS = 7;
    localparam int unsigned CFG_IRQ_EN  = 12;
    localparam logic [15:0] CFG_RESET   = 16'h0000;
    // status bits
    localparam int unsigned ST_HI    = 0;
    localparam int unsigned ST_LO    = 1;
    localparam int unsigned ST_FLT   = 2;
    localparam int unsigned ST_NOFLT = 3;
    localparam int unsigned ST_HALT  = 4;
    // fault codes
    localparam int unsigned F_OVER  = 0;
    localparam int unsigned F_UNDER = 1;
    localparam int unsigned F_OPEN  = 2;
    localparam int unsigned F_EXP   = 3;
    localparam int unsigned F_ADC   = 4;
    localparam int unsigned F_SCALE = 5;
    localparam int unsigned F_XCFG  = 6;
    localparam int unsigned NFAULT  = 7;
    typedef enum logic [1:0] {AAFM_RUN, AAFM_HALT} aafm_state_e;
endpackage : aafm_pkg

// *** rtl/aafm_top.sv ***
// analog alarm comparator and fault monitor, per channel
// assumes samples, raw flags and bus strobes are on core_clk
`timescale 1ns/1ps
// Function
// - value above high threshold sets high contact, below low sets low
// - one alarm event per crossing, not per sample
// - alarm event raises channel interrupt when its enable is set
// - alarms never change operation or the reported value
// - threshold at full scale magnitude disables that alarm
// - thresholds default to plus and minus 32767
// - thresholds may be rewritten at run time and apply next
// - fault sets fault contact; message sent unless reporting disabled
// - each fault reported once until it clears and recurs
// - fault contact on any fault, no-fault contact otherwise
// - scaled value above 32767 flags overrange, clamps to 32767
// - raw converter overrange also flags overrange
// - scaled value below -32767 flags underrange, clamps there
// - raw converter underrange also flags underrange
// - current mode below 2 mA flags open wire
// - expander not responding flags a fault
// - converter failure reports fault, lights off, halts
// - scaling zero point out of range reports fault and halts
// - power-up expander scan mismatch reports configuration error
// - alarm comparison only on base channels
// - config bit 8 disables reporting, bit 13 enables interrupts
module aafm_top
    import aafm_pkg::*;
#(
    parameter int unsigned NCH = 8,
    parameter int unsigned CW  = 3
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rstn,
    // register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [15:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [15:0]         reg_rdata,
    // sample input
    input  wire logic                smp_valid,
    input  wire logic [CW-1:0]       smp_ch,
    input  wire logic signed [19:0]  smp_scaled,
    input  wire logic [15:0]         smp_raw_mag,
    input  wire logic                smp_adc_over,
    input  wire logic                smp_adc_under,
    input  wire logic                smp_current_mode,
    input  wire logic                smp_base,
    // module level conditions
    input  wire logic                exp_no_resp,
    input  wire logic                adc_comm_fail,
    input  wire logic                scale_zero_bad,
    input  wire logic                exp_scan_done,
    input  wire logic                exp_scan_mismatch,
    // channel outputs
    output logic      [NCH-1:0]      high_alarm_contact,
    output logic      [NCH-1:0]      low_alarm_contact,
    output logic      [NCH-1:0]      fault_contact,
    output logic      [NCH-1:0]      no_fault_contact,
    output logic      [NCH-1:0]      alarm_irq,
    output logic                     fault_msg_valid,
    output logic      [15:0]         fault_msg,
    output logic                     leds_on,
    output logic                     halted
);
    import aafm_pkg::*;

    // ==========================================================
    // functions
    function automatic logic signed [15:0] clamp(
        input logic signed [19:0] v);
        if (v > WIDE_POS) begin
            return FULL_POS;
        end else if (v < WIDE_NEG) begin
            return FULL_NEG;
        end
        return v[15:0];
    endfunction : clamp

    function automatic logic [15:0] msg(input logic [CW-1:0] ch,
        input int unsigned code);
        return {5'h00, ch, 5'h00, 3'(code)};
    endfunction : msg

    // ==========================================================
    // configuration storage
    logic [CW-1:0]          sel_q;
    logic [15:0]            cfg_q [NCH];
    logic signed [15:0]     hi_q  [NCH];
    logic signed [15:0]     lo_q  [NCH];
    logic [15:0]            val_rd;
    logic                   val_we;
    logic signed [15:0]     val_c;
    aafm_state_e            state_q;
    logic                   run;

    assign run = (state_q == AAFM_RUN);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sel_q <= '0;
        end else if (reg_wr && reg_addr == ADDR_CHSEL) begin
            sel_q <= reg_wdata[CW-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NCH; i++) begin
                cfg_q[i] <= CFG_RESET;
                hi_q[i]  <= FULL_POS;
                lo_q[i]  <= FULL_NEG;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_CFG: cfg_q[sel_q] <= reg_wdata;
                ADDR_HI:  hi_q[sel_q]  <= reg_wdata;
                ADDR_LO:  lo_q[sel_q]  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // reported value memory, clamped and untouched by alarms
    assign val_c  = clamp(smp_scaled);
    assign val_we = smp_valid && run;

    aafm_mem #(.AW(CW), .DW(16), .INIT(16'h0000)) u_val (
        .core_clk (core_clk),
        .rstn     (rstn),
        .we       (val_we),
        .waddr    (smp_ch),
        .wdata    (val_c),
        .raddr    (sel_q),
        .rdata    (val_rd)
    );

    // ==========================================================
    // alarm comparator
    logic [NCH-1:0] hi_lvl_q;
    logic [NCH-1:0] lo_lvl_q;
    logic [NCH-1:0] hi_lat_q;
    logic [NCH-1:0] lo_lat_q;
    logic           hi_now;
    logic           lo_now;
    logic           ack_wr;

    assign hi_now = smp_base && hi_q[smp_ch] != FULL_POS
                    && val_c > hi_q[smp_ch];
    assign lo_now = smp_base && lo_q[smp_ch] != FULL_NEG
                    && val_c < lo_q[smp_ch];
    assign ack_wr = reg_wr && reg_addr == ADDR_ACK;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hi_lvl_q <= '0;
            lo_lvl_q <= '0;
        end else if (val_we) begin
            hi_lvl_q[smp_ch] <= hi_now;
            lo_lvl_q[smp_ch] <= lo_now;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hi_lat_q <= '0;
            lo_lat_q <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (ack_wr && reg_wdata[CW-1:0] == CW'(i)) begin
                    hi_lat_q[i] <= 1'b0;
                    lo_lat_q[i] <= 1'b0;
                end
                // set wins over acknowledge
                if (val_we && smp_ch == CW'(i)) begin
                    if (hi_now && !hi_lvl_q[i]) begin
                        hi_lat_q[i] <= 1'b1;
                    end
                    if (lo_now && !lo_lvl_q[i]) begin
                        lo_lat_q[i] <= 1'b1;
                    end
                end
            end
        end
    end

    assign high_alarm_contact = hi_lat_q;
    assign low_alarm_contact  = lo_lat_q;

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            alarm_irq[i] = cfg_q[i][CFG_IRQ_EN]
                           && (hi_lat_q[i] || lo_lat_q[i]);
        end
    end

    // ==========================================================
    // fault detection
    logic [NFAULT-1:0] flt_q [NCH];
    logic [NFAULT-1:0] rep_q [NCH];
    logic [NFAULT-1:0] mod_f;
    logic [NFAULT-1:0] smp_f;
    logic [NFAULT-1:0] xcfg_q;

    always_comb begin
        smp_f = '0;
        smp_f[F_OVER]  = smp_scaled > WIDE_POS || smp_adc_over;
        smp_f[F_UNDER] = smp_scaled < WIDE_NEG || smp_adc_under;
        smp_f[F_OPEN]  = smp_current_mode
                         && smp_raw_mag < OPEN_WIRE_RAW;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            xcfg_q <= '0;
        end else if (exp_scan_done) begin
            xcfg_q[F_XCFG] <= exp_scan_mismatch;
        end
    end

    always_comb begin
        mod_f = xcfg_q;
        mod_f[F_EXP]   = exp_no_resp;
        mod_f[F_ADC]   = adc_comm_fail;
        mod_f[F_SCALE] = scale_zero_bad;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NCH; i++) begin
                flt_q[i] <= '0;
            end
        end else if (val_we) begin
            flt_q[smp_ch] <= smp_f;
        end
    end

    // one message per cycle, lowest pending channel and code first
    logic           pick;
    logic [CW-1:0]  pick_ch;
    int unsigned    pick_code;
    logic [NFAULT-1:0] cur;

    always_comb begin
        pick = 1'b0;
        pick_ch = '0;
        pick_code = 0;
        cur = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            cur = flt_q[i] | mod_f;
            for (int k = NFAULT - 1; k >= 0; k--) begin
                if (cur[k] && !rep_q[i][k]
                    && !cfg_q[i][CFG_FLT_DIS]) begin
                    pick = 1'b1;
                    pick_ch = CW'(i);
                    pick_code = k;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NCH; i++) begin
                rep_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                // rearm when the condition is gone
                rep_q[i] <= rep_q[i] & (flt_q[i] | mod_f);
            end
            if (pick) begin
                rep_q[pick_ch][pick_code] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fault_msg_valid <= 1'b0;
            fault_msg       <= 16'h0000;
        end else begin
            fault_msg_valid <= pick;
            if (pick) begin
                fault_msg <= msg(pick_ch, pick_code);
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            fault_contact[i]    = |(flt_q[i] | mod_f);
            no_fault_contact[i] = ~fault_contact[i];
        end
    end

    // ==========================================================
    // halt on converter failure or bad scaling
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= AAFM_RUN;
        end else begin
            case (state_q)
                AAFM_RUN: begin
                    if (adc_comm_fail || scale_zero_bad) begin
                        state_q <= AAFM_HALT;
                    end
                end
                AAFM_HALT: state_q <= AAFM_HALT;
                default:   state_q <= AAFM_RUN;
            endcase
        end
    end

    assign halted  = !run;
    assign leds_on = run;

    // ==========================================================
    // read port
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CFG:   reg_rdata <= cfg_q[sel_q];
                ADDR_HI:    reg_rdata <= hi_q[sel_q];
                ADDR_LO:    reg_rdata <= lo_q[sel_q];
                ADDR_STAT:  reg_rdata <= {11'h000, halted,
                    no_fault_contact[sel_q], fault_contact[sel_q],
                    lo_lat_q[sel_q], hi_lat_q[sel_q]};
                ADDR_VALUE: reg_rdata <= val_rd;
                ADDR_FAULT: reg_rdata <= {9'h000,
                    flt_q[sel_q] | mod_f};
                ADDR_MSG:   reg_rdata <= fault_msg;
                ADDR_CHSEL: reg_rdata <= {13'h0000, sel_q};
                default:    reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ==========================================================
    // checks
    property p_clamp_hi;
        @(posedge core_clk) disable iff (!rstn)
        val_we && smp_scaled > WIDE_POS |-> val_c == FULL_POS;
    endproperty
    a_clamp_hi: assert property (p_clamp_hi)
        else $error("overrange not clamped");

    property p_clamp_lo;
        @(posedge core_clk) disable iff (!rstn)
        val_we && smp_scaled < WIDE_NEG |-> val_c == FULL_NEG;
    endproperty
    a_clamp_lo: assert property (p_clamp_lo)
        else $error("underrange not clamped");

    property p_halt;
        @(posedge core_clk) disable iff (!rstn)
        run && adc_comm_fail |=> halted && !leds_on;
    endproperty
    a_halt: assert property (p_halt)
        else $error("no halt on converter failure");

    property p_scale_halt;
        @(posedge core_clk) disable iff (!rstn)
        scale_zero_bad |=> halted;
    endproperty
    a_scale_halt: assert property (p_scale_halt)
        else $error("no halt on scaling fault");

    property p_contacts;
        @(posedge core_clk) disable iff (!rstn)
        fault_contact == ~no_fault_contact;
    endproperty
    a_contacts: assert property (p_contacts)
        else $error("fault contacts not complementary");

    property p_hi_set;
        @(posedge core_clk) disable iff (!rstn)
        val_we && hi_now && !hi_lvl_q[smp_ch]
        |=> high_alarm_contact[$past(smp_ch)];
    endproperty
    a_hi_set: assert property (p_hi_set)
        else $error("high alarm not raised");

    property p_once;
        @(posedge core_clk) disable iff (!rstn)
        fault_msg_valid |=> !fault_msg_valid || fault_msg != $past(fault_msg);
    endproperty
    a_once: assert property (p_once)
        else $error("fault reported twice");

    property p_irq;
        @(posedge core_clk) disable iff (!rstn)
        alarm_irq[sel_q] |-> cfg_q[sel_q][CFG_IRQ_EN];
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without enable");
endmodule : aafm_top
